// [bold_deadtime.v]
// One complementary drive leg with dead-time insertion.
// Assumes a raw pwm level on the same clock; counts are system cycles.
`timescale 1ns/1ps
module bold_deadtime
(
  input  wire        sys_clk,
  input  wire        resetn,
  input  wire        enable,
  input  wire        pwm_in,
  input  wire [15:0] rise_cycles,
  input  wire [15:0] fall_cycles,
  output reg         high_out,
  output reg         low_out
);

  reg [15:0] wait_reg;
  reg        last_reg;

  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      high_out <= 1'b0;
      low_out  <= 1'b0;
      wait_reg <= 16'h0000;
      last_reg <= 1'b0;
    end
    else if (!enable)
    begin
      high_out <= 1'b0;
      low_out  <= 1'b0;
      wait_reg <= 16'h0000;
      last_reg <= 1'b0;
    end
    else if (pwm_in != last_reg)
    begin
      // Both off first; partner rises only after the gap
      high_out <= 1'b0;
      low_out  <= 1'b0;
      last_reg <= pwm_in;
      wait_reg <= pwm_in ? rise_cycles : fall_cycles;
    end
    else if (wait_reg != 16'h0000)
      wait_reg <= wait_reg - 16'h0001;
    else
    begin
      high_out <= last_reg;
      low_out  <= ~last_reg;
    end
  end

endmodule // bold_deadtime

// [bold_defs.vh]
// Constants for the open-loop buck drive and load sequencer.
// Assumes a single 125 MHz system clock and plain-port register access.
// Summary of operation
// - Dead-time tick is timer clock times eight
// - Wait 75 ticks before raising high side
// - Wait 300 ticks before raising low side
// - Never both drive outputs high together
// - Open loop: no compute interrupt, fixed duty
// - Drive outputs complementary apart from dead-time
// - Bank one on when its enable low
// - Bank two on when its enable low
// - One dedicated pin gates each bank
// - Left selects manual; up/down steps load
// - Right selects automatic transient mode
// - Green shows bank one, orange bank two
// - Automatic mode toggles bank two each half-second
`ifndef BOLD_DEFS_VH
`define BOLD_DEFS_VH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define BOLD_ADDR_CTRL     4'h0
`define BOLD_ADDR_STATUS   4'h1
`define BOLD_ADDR_PERIOD   4'h2
`define BOLD_ADDR_DUTY     4'h3
`define BOLD_ADDR_DT_RISE  4'h4
`define BOLD_ADDR_DT_FALL  4'h5
`define BOLD_ADDR_ID       4'hf

// CTRL fields
`define BOLD_CTRL_RUN      0
`define BOLD_CTRL_OPEN     1
`define BOLD_CTRL_LOAD_GO  2
`define BOLD_CTRL_CIRQ     3

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define BOLD_DTG_MULT      8
`define BOLD_TIMER_MHZ     170
`define BOLD_SYS_MHZ       125
`define BOLD_DT_RISE_TICKS 16'd75
`define BOLD_DT_FALL_TICKS 16'd300
`define BOLD_PERIOD_RST    16'h0271
`define BOLD_DUTY_RST      16'h019c
`define BOLD_HALF_SEC_MS   500
`define BOLD_CYC_PER_MS    32'd125000
`define BOLD_DT_CYC_RST    16'hffff
`define BOLD_ID_VALUE      16'h5a3c

`endif

// [bold_load_seq.v]
// Load bank sequencer: manual steps or automatic transient toggling.
// Assumes joystick inputs already synchronised and edge-detected.
`timescale 1ns/1ps
module bold_load_seq
(
  input  wire        sys_clk,
  input  wire        resetn,
  input  wire        start,
  input  wire        left_pulse,
  input  wire        right_pulse,
  input  wire        up_pulse,
  input  wire        down_pulse,
  input  wire [31:0] half_sec_cycles,
  output reg         bank_one_on,
  output reg         bank_two_on,
  output reg         auto_mode
);

  reg [1:0]  step_reg;
  reg [31:0] tmr_reg;

  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      step_reg    <= 2'd0;
      tmr_reg     <= 32'h00000000;
      auto_mode   <= 1'b0;
      bank_one_on <= 1'b0;
      bank_two_on <= 1'b0;
    end
    else if (!start)
    begin
      step_reg    <= 2'd0;
      auto_mode   <= 1'b0;
      bank_one_on <= 1'b0;
      bank_two_on <= 1'b0;
    end
    else
    begin
      if (right_pulse)
      begin
        auto_mode <= 1'b1;
        tmr_reg   <= 32'h00000000;
      end
      else if (left_pulse)
        auto_mode <= 1'b0;
      if (!auto_mode)
      begin
        if (up_pulse && step_reg != 2'd2)
          step_reg <= step_reg + 2'd1;
        else if (down_pulse && step_reg != 2'd0)
          step_reg <= step_reg - 2'd1;
        bank_one_on <= (step_reg != 2'd0);
        bank_two_on <= (step_reg == 2'd2);
      end
      else
      begin
        // Alternates 50% and 100% with no further input
        bank_one_on <= 1'b1;
        if (tmr_reg >= half_sec_cycles - 32'h00000001)
        begin
          tmr_reg     <= 32'h00000000;
          bank_two_on <= ~bank_two_on;
        end
        else
          tmr_reg <= tmr_reg + 32'h00000001;
      end
    end
  end

endmodule // bold_load_seq

// [bold_stage_model.sv]
// Power stage stand-in: gate pair and two load switches.
// Assumes drive levels straight from the drive block.
`timescale 1ns/1ps
module bold_stage_model
(
  input  wire         sys_clk,
  input  wire         high_gate,
  input  wire         low_gate,
  input  wire         bank_one_n,
  input  wire         bank_two_n,
  output logic [7:0]  load_pct,
  output logic [31:0] shoot_cnt
);
  // Each bank is one switch, closed while its enable is low
  assign load_pct = (bank_one_n ? 8'h00 : 8'h32)
                  + (bank_two_n ? 8'h00 : 8'h32);
  initial shoot_cnt = 32'h0;
  always @(posedge sys_clk)
    if (high_gate && low_gate)
      shoot_cnt <= shoot_cnt + 32'h1;
endmodule // bold_stage_model

// [bold_tb.sv]
// Self-checking bench for the open-loop drive and load sequencer.
// Assumes default dead-times and a shortened half-second.
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin \
    tests_run++; \
    if ((got) !== (exp)) \
    begin \
      err_count++; \
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); \
    end \
  end
module testbench;
  localparam int HALF = 50;
  localparam [15:0] ID = 16'h1234; // Arbitrary value
  logic        sys_clk;
  logic        resetn;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [3:0]  joy;
  wire  [15:0] reg_rdata;
  wire         hs;
  wire         ls;
  wire         b1n;
  wire         b2n;
  wire         led_g;
  wire         led_o;
  wire         irq_en;
  wire  [7:0]  load_pct;
  wire  [31:0] shoot_cnt;
  int          err_count;
  int          tests_run;
  int          i;
  int          k;
  int          n;
  logic        lvl;
  // Joystick {left,right,up,down}, then load percent expected
  logic [11:0] rows [0:6] = '{12'h800, 12'h232, 12'h264, 12'h264,
                              12'h132, 12'h100, 12'h100};

  bold_top #(.HALF_SEC_CYC(HALF), .ID_VALUE(ID)) i_dut (
    .sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .joy_left(joy[3]), .joy_right(joy[2]),
    .joy_up(joy[1]), .joy_down(joy[0]), .high_side_drive(hs),
    .low_side_drive(ls), .bank_one_enable_n(b1n),
    .bank_two_enable_n(b2n), .led_green(led_g), .led_orange(led_o),
    .compute_irq_en(irq_en));
  bold_stage_model i_stage (
    .sys_clk(sys_clk), .high_gate(hs), .low_gate(ls),
    .bank_one_n(b1n), .bank_two_n(b2n), .load_pct(load_pct),
    .shoot_cnt(shoot_cnt));

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 `CHK(reg_rdata, e)
  endtask
  // Pin held long enough to clear the three-flop synchroniser
  task automatic press(input logic [3:0] j);
    @(posedge sys_clk);
    joy <= j;
    repeat (6) @(posedge sys_clk);
    joy <= 4'h0;
    repeat (12) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask
  // Cycles with both gates off before the named side rises
  task automatic gap(input bit hi_next, output int c);
    int t;
    c = 0;
    for (t = 0; t < 2000 && !(hi_next ? ls : hs); t++) @(negedge sys_clk);
    for (t = 0; t < 2000 && (hi_next ? ls : hs); t++) @(negedge sys_clk);
    for (t = 0; t < 2000 && !(hi_next ? hs : ls); t++)
      @(negedge sys_clk) c++;
  endtask

  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  initial
  begin
    #200000;
    err_count++;
    end_sim;
  end
  initial
  begin
    resetn = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    joy = 4'h0;
    err_count = 0;
    tests_run = 0;
    repeat (12) @(posedge sys_clk);
    resetn <= 1'b1;
    @(negedge sys_clk);
    `CHK({hs, ls, b1n, b2n, led_g, led_o, irq_en}, 7'h18)
    rd(4'hf, ID);
    rd(4'h9, 16'h0000);
    rd(4'h4, 16'd75);
    wr(4'h0, 16'h0007);
    rd(4'h0, 16'h0007);
    for (i = 0; i < 7; i++)
    begin
      press(rows[i][11:8]);
      `CHK(load_pct, rows[i][7:0])
      `CHK({led_g, led_o}, {|rows[i][7:0], rows[i][7:0] == 8'h64})
    end
    gap(1'b1, n);
    `CHK(n inside {[7:12]}, 1'b1)
    gap(1'b0, n);
    `CHK(n inside {[28:33]}, 1'b1)
    wr(4'h0, 16'h000f);
    repeat (3) @(posedge sys_clk);
    #1 `CHK(irq_en, 1'b0)
    wr(4'h0, 16'h000d);
    repeat (3) @(posedge sys_clk);
    #1 `CHK(irq_en, 1'b1)
    wr(4'h0, 16'h0007);
    press(4'h4);
    `CHK(b1n, 1'b0)
    lvl = b2n;
    for (k = 0; k < 200 && b2n === lvl; k++) @(negedge sys_clk);
    lvl = b2n;
    n = 0;
    for (k = 0; k < 200 && b2n === lvl; k++) @(negedge sys_clk) n++;
    `CHK(n, HALF)
    wr(4'h0, 16'h0000);
    repeat (4) @(negedge sys_clk);
    `CHK({hs, ls, b1n, b2n}, 4'h3)
    `CHK(shoot_cnt, 32'h0)
    rd(4'h1, 16'h0000);
    end_sim;
  end
endmodule // testbench

// [bold_top.v]
// Open-loop buck drive with dead-time and load bank sequencing.
// Assumes one 125 MHz clock, raw joystick pins, plain register port.
// Joystick pins are asynchronous; the register port is synchronous.
`timescale 1ns/1ps
`include "bold_defs.vh"
module bold_top
#(
  parameter [15:0] DT_RISE_TICKS = `BOLD_DT_RISE_TICKS,
  parameter [15:0] DT_FALL_TICKS = `BOLD_DT_FALL_TICKS,
  parameter [15:0] DUTY_INIT     = `BOLD_DUTY_RST,
  parameter [31:0] HALF_SEC_CYC  = `BOLD_HALF_SEC_MS * `BOLD_CYC_PER_MS,
  parameter [15:0] ID_VALUE      = `BOLD_ID_VALUE // Arbitrary value
)
(
  input  wire        sys_clk,
  input  wire        resetn,
  input  wire [3:0]  reg_addr,
  input  wire [15:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [15:0] reg_rdata,
  input  wire        joy_left,
  input  wire        joy_right,
  input  wire        joy_up,
  input  wire        joy_down,
  output reg         high_side_drive,
  output reg         low_side_drive,
  output reg         bank_one_enable_n,
  output reg         bank_two_enable_n,
  output reg         led_green,
  output reg         led_orange,
  output reg         compute_irq_en
);

  // ----------------------------------------------------------------
  // Dead-time tick conversion
  // ----------------------------------------------------------------
  // Ticks run at timer clock times eight; convert to system cycles,
  // rounding up so the gap is never shorter than asked.
  function [15:0] ticks_to_cycles;
    input [15:0] ticks;
    reg   [31:0] prod;
    begin
      prod = {16'h0000, ticks} * `BOLD_SYS_MHZ;
      prod = (prod + (`BOLD_TIMER_MHZ * `BOLD_DTG_MULT) - 1)
             / (`BOLD_TIMER_MHZ * `BOLD_DTG_MULT);
      if (prod == 32'h00000000)
        prod = 32'h00000001;
      ticks_to_cycles = prod[15:0];
    end
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg        run_reg;
  reg        open_reg;
  reg        load_go_reg;
  reg        cirq_reg;
  reg [15:0] period_reg;
  reg [15:0] duty_reg;
  reg [15:0] dt_rise_reg;
  reg [15:0] dt_fall_reg;
  reg [15:0] cnt_reg;
  reg        pwm_reg;

  wire       dt_high;
  wire       dt_low;
  wire       b1_on;
  wire       b2_on;
  wire       auto_on;

  // OPEN comes up set, so the duty is fixed from reset
  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      run_reg     <= 1'b0;
      open_reg    <= 1'b1;
      load_go_reg <= 1'b0;
      cirq_reg    <= 1'b0;
      period_reg  <= `BOLD_PERIOD_RST;
      duty_reg    <= `BOLD_DUTY_RST;
      dt_rise_reg <= `BOLD_DT_RISE_TICKS;
      dt_fall_reg <= `BOLD_DT_FALL_TICKS;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `BOLD_ADDR_CTRL:
        begin
          run_reg     <= reg_wdata[`BOLD_CTRL_RUN];
          open_reg    <= reg_wdata[`BOLD_CTRL_OPEN];
          load_go_reg <= reg_wdata[`BOLD_CTRL_LOAD_GO];
          cirq_reg    <= reg_wdata[`BOLD_CTRL_CIRQ];
        end
        `BOLD_ADDR_PERIOD:  period_reg  <= reg_wdata;
        `BOLD_ADDR_DUTY:    duty_reg    <= reg_wdata;
        `BOLD_ADDR_DT_RISE: dt_rise_reg <= reg_wdata;
        `BOLD_ADDR_DT_FALL: dt_fall_reg <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Live state for software, sampled on the read strobe only
  wire [15:0] status_word = {10'h000, auto_on, b2_on, b1_on,
                             low_side_drive, high_side_drive, pwm_reg};

  // Read data valid the cycle after the strobe, zero otherwise
  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      reg_rdata <= 16'h0000;
    else if (reg_rd)
    begin
      case (reg_addr)
        `BOLD_ADDR_CTRL:
          reg_rdata <= {12'h000, cirq_reg, load_go_reg, open_reg, run_reg};
        `BOLD_ADDR_STATUS:
          reg_rdata <= status_word;
        `BOLD_ADDR_PERIOD:  reg_rdata <= period_reg;
        `BOLD_ADDR_DUTY:    reg_rdata <= duty_reg;
        `BOLD_ADDR_DT_RISE: reg_rdata <= dt_rise_reg;
        `BOLD_ADDR_DT_FALL: reg_rdata <= dt_fall_reg;
        `BOLD_ADDR_ID:      reg_rdata <= ID_VALUE;
        default:            reg_rdata <= 16'h0000;
      endcase
    end
    else
      reg_rdata <= 16'h0000;
  end

  // ----------------------------------------------------------------
  // Fixed-duty pwm
  // ----------------------------------------------------------------
  // Open loop uses the parameter duty; closed loop would take the
  // software-written value, which here stands in for a regulator.
  // The counter wraps after PERIOD, so one pwm cycle is PERIOD+1 clocks.
  wire [15:0] duty_sel = open_reg ? DUTY_INIT : duty_reg;

  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt_reg <= 16'h0000;
      pwm_reg <= 1'b0;
    end
    else if (!run_reg)
    begin
      cnt_reg <= 16'h0000;
      pwm_reg <= 1'b0;
    end
    else
    begin
      cnt_reg <= (cnt_reg >= period_reg) ? 16'h0000 : cnt_reg + 16'h0001;
      pwm_reg <= (cnt_reg < duty_sel);
    end
  end

  // Rise/fall registers reset to the parameter-independent defaults;
  // parameters override when software leaves them at reset value.
  wire [15:0] rise_t = (dt_rise_reg == `BOLD_DT_RISE_TICKS) ?
                       DT_RISE_TICKS : dt_rise_reg;
  wire [15:0] fall_t = (dt_fall_reg == `BOLD_DT_FALL_TICKS) ?
                       DT_FALL_TICKS : dt_fall_reg;

  // Converted once per cycle into flops so the divide stays out of
  // the drive path; the longest gap stands until the first update.
  // Software changes to the dead-times take effect one cycle later.
  reg [15:0] rise_cyc_reg;
  reg [15:0] fall_cyc_reg;

  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rise_cyc_reg <= `BOLD_DT_CYC_RST;
      fall_cyc_reg <= `BOLD_DT_CYC_RST;
    end
    else
    begin
      rise_cyc_reg <= ticks_to_cycles(rise_t);
      fall_cyc_reg <= ticks_to_cycles(fall_t);
    end
  end

  bold_deadtime u_dt
  (
    .sys_clk     (sys_clk),
    .resetn      (resetn),
    .enable      (run_reg),
    .pwm_in      (pwm_reg),
    .rise_cycles (rise_cyc_reg),
    .fall_cycles (fall_cyc_reg),
    .high_out    (dt_high),
    .low_out     (dt_low)
  );

  // ----------------------------------------------------------------
  // Joystick synchronisers
  // ----------------------------------------------------------------
  // Three stages; a change counts once stages two and three agree.
  // Each pin keeps its own flops, so no vector has several drivers.
  // Pins idle low, so the reset values give no false edge.
  wire [3:0] joy_raw;
  wire [3:0] pulse_w;

  assign joy_raw = {joy_down, joy_up, joy_right, joy_left};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : g_sync
      reg s1_reg;
      reg s2_reg;
      reg s3_reg;
      reg lvl_reg;
      reg pulse_reg;

      always @(posedge sys_clk or negedge resetn)
      begin
        if (!resetn)
        begin
          s1_reg    <= 1'b0;
          s2_reg    <= 1'b0;
          s3_reg    <= 1'b0;
          lvl_reg   <= 1'b0;
          pulse_reg <= 1'b0;
        end
        else
        begin
          s1_reg    <= joy_raw[gi];
          s2_reg    <= s1_reg;
          s3_reg    <= s2_reg;
          if (s2_reg == s3_reg)
            lvl_reg <= s3_reg;
          pulse_reg <= (s2_reg == s3_reg) && s3_reg && !lvl_reg;
        end
      end

      assign pulse_w[gi] = pulse_reg;
    end
  endgenerate

  bold_load_seq u_load
  (
    .sys_clk         (sys_clk),
    .resetn          (resetn),
    .start           (load_go_reg),
    .left_pulse      (pulse_w[0]),
    .right_pulse     (pulse_w[1]),
    .up_pulse        (pulse_w[2]),
    .down_pulse      (pulse_w[3]),
    .half_sec_cycles (HALF_SEC_CYC),
    .bank_one_on     (b1_on),
    .bank_two_on     (b2_on),
    .auto_mode       (auto_on)
  );

  // ----------------------------------------------------------------
  // Drive output flops
  // ----------------------------------------------------------------
  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      high_side_drive <= 1'b0;
      low_side_drive  <= 1'b0;
      compute_irq_en  <= 1'b0;
    end
    else
    begin
      // Final guard keeps the pair exclusive even on a bad leg
      high_side_drive <= dt_high & ~dt_low;
      low_side_drive  <= dt_low & ~dt_high;
      compute_irq_en  <= cirq_reg & ~open_reg;
    end
  end

  // ----------------------------------------------------------------
  // Load switch and indicator flops
  // ----------------------------------------------------------------
  // Indicators come from the same bank bits, so they match the enables
  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      bank_one_enable_n <= 1'b1;
      bank_two_enable_n <= 1'b1;
      led_green         <= 1'b0;
      led_orange        <= 1'b0;
    end
    else
    begin
      bank_one_enable_n <= ~b1_on;
      bank_two_enable_n <= ~b2_on;
      led_green         <= b1_on;
      led_orange        <= b2_on;
    end
  end

endmodule // bold_top

// [bold_top_props.sv]
// Assertions on the drive and load ports of the top level.
// Assumes one clock domain and the default register map.
`timescale 1ns/1ps
module bold_top_props
#(
  parameter [15:0] DT_RISE_TICKS = 16'd75,
  parameter [15:0] DT_FALL_TICKS = 16'd300
)
(
  input wire        sys_clk,
  input wire        resetn,
  input wire [3:0]  reg_addr,
  input wire [15:0] reg_wdata,
  input wire        reg_wr,
  input wire        high_side_drive,
  input wire        low_side_drive,
  input wire        bank_one_enable_n,
  input wire        bank_two_enable_n,
  input wire        led_green,
  input wire        led_orange,
  input wire        compute_irq_en
);
  // Ticks rounded up to whole cycles, so the gap never falls short
  localparam int RISE_CYC = (DT_RISE_TICKS * 125 + 1359) / 1360;
  localparam int FALL_CYC = (DT_FALL_TICKS * 125 + 1359) / 1360;
  logic [8:0] lo_quiet;
  logic [8:0] hi_quiet;
  wire        irq_wr;
  assign irq_wr = reg_wr && reg_addr == 4'h0 && reg_wdata[3]
                  && !reg_wdata[1];
  always @(posedge sys_clk or negedge resetn)
    if (!resetn)
    begin
      // Both drives are off through reset, so start fully quiet
      lo_quiet <= 9'h1ff;
      hi_quiet <= 9'h1ff;
    end
    else
    begin
      lo_quiet <= low_side_drive ? 9'h000 : lo_quiet + {8'h00, ~&lo_quiet};
      hi_quiet <= high_side_drive ? 9'h000 : hi_quiet + {8'h00, ~&hi_quiet};
    end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  sequence outs_idle;
    !high_side_drive && !low_side_drive && bank_one_enable_n
    && bank_two_enable_n && !led_green && !led_orange;
  endsequence
  sequence cirq_write;
    $past(irq_wr, 1) || $past(irq_wr, 2);
  endsequence
  no_overlap_a:
    assert property (!(high_side_drive && low_side_drive))
      else $error("both drives high");
  rise_gap_a:
    assert property ($rose(high_side_drive) |-> lo_quiet >= RISE_CYC)
      else $error("rising dead-time short");
  fall_gap_a:
    assert property ($rose(low_side_drive) |-> hi_quiet >= FALL_CYC)
      else $error("falling dead-time short");
  green_led_a:
    assert property (led_green == !bank_one_enable_n)
      else $error("green led wrong");
  orange_led_a:
    assert property (led_orange == !bank_two_enable_n)
      else $error("orange led wrong");
  step_order_a:
    assert property (!bank_two_enable_n |-> !bank_one_enable_n)
      else $error("bank two without bank one");
  reset_idle_a:
    assert property ($rose(resetn) |-> outs_idle)
      else $error("outputs active after reset");
  irq_cause_a:
    assert property ($rose(compute_irq_en) |-> cirq_write)
      else $error("irq enabled without closed loop");
endmodule // bold_top_props

bind bold_top bold_top_props #(
  .DT_RISE_TICKS(DT_RISE_TICKS),
  .DT_FALL_TICKS(DT_FALL_TICKS)
) i_props (
  .sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .high_side_drive(high_side_drive), .low_side_drive(low_side_drive),
  .bank_one_enable_n(bank_one_enable_n),
  .bank_two_enable_n(bank_two_enable_n),
  .led_green(led_green), .led_orange(led_orange),
  .compute_irq_en(compute_irq_en)
);
